// ===== core/psu_pkg.sv
package psu_pkg;
  localparam logic [5:0]  MAJOR_GROUP      = 6'h00;
  localparam logic [10:0] MINOR_HWS        = 11'h28D;
  localparam logic [10:0] MINOR_HWS_RND    = 11'h68D;
  localparam logic [10:0] MINOR_PAIR       = 11'h30D;
  localparam logic [10:0] MINOR_PAIR_SAT   = 11'h70D;
  localparam logic [10:0] MINOR_QUAD       = 11'h2CD;
  localparam logic [10:0] MINOR_QUAD_SAT   = 11'h6CD;
  localparam int          MAJOR_MSB        = 31;
  localparam int          MAJOR_LSB        = 26;
  localparam int          FIRST_SRC_MSB    = 20;
  localparam int          FIRST_SRC_LSB    = 16;
  localparam int          SECOND_SRC_MSB   = 25;
  localparam int          SECOND_SRC_LSB   = 21;
  localparam int          DEST_MSB         = 15;
  localparam int          DEST_LSB         = 11;
  localparam int          MINOR_MSB        = 10;
  localparam int          OUFLAG_BIT       = 20;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
  localparam logic [31:0] RESULT_RESET     = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NONE      = 3'h0,
    OP_HWS       = 3'h1,
    OP_HWS_RND   = 3'h3,
    OP_PAIR      = 3'h2,
    OP_PAIR_SAT  = 3'h6,
    OP_QUAD      = 3'h7,
    OP_QUAD_SAT  = 3'h5
  } sub_op_t;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [31:0] data;
  } wb_t;
endpackage

// ===== core/sub_decoder.sv
`timescale 1ns/10ps
module sub_decoder (
  input  wire logic [31:0]      insn,
  output psu_pkg::sub_op_t      op,
  output logic [4:0]            first_sel,
  output logic [4:0]            second_sel,
  output logic [4:0]            dest_sel
);
  logic [10:0] minor;
  assign minor      = insn[psu_pkg::MINOR_MSB:0];
  assign first_sel  = insn[psu_pkg::FIRST_SRC_MSB:psu_pkg::FIRST_SRC_LSB];
  assign second_sel = insn[psu_pkg::SECOND_SRC_MSB:psu_pkg::SECOND_SRC_LSB];
  assign dest_sel   = insn[psu_pkg::DEST_MSB:psu_pkg::DEST_LSB];

  always_comb begin
    op = psu_pkg::OP_NONE;
    if (insn[psu_pkg::MAJOR_MSB:psu_pkg::MAJOR_LSB] == psu_pkg::MAJOR_GROUP) begin
      if (minor == psu_pkg::MINOR_HWS)           op = psu_pkg::OP_HWS;
      else if (minor == psu_pkg::MINOR_HWS_RND)  op = psu_pkg::OP_HWS_RND;
      else if (minor == psu_pkg::MINOR_PAIR)     op = psu_pkg::OP_PAIR;
      else if (minor == psu_pkg::MINOR_PAIR_SAT) op = psu_pkg::OP_PAIR_SAT;
      else if (minor == psu_pkg::MINOR_QUAD)     op = psu_pkg::OP_QUAD;
      else if (minor == psu_pkg::MINOR_QUAD_SAT) op = psu_pkg::OP_QUAD_SAT;
    end
  end
endmodule

// ===== core/lane_sub.sv
`timescale 1ns/10ps
// Unsigned lane subtract with optional clamp to zero on underflow
module lane_sub #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] minuend,
  input  wire logic [W-1:0] subtrahend,
  input  wire logic         saturate,
  output logic [W-1:0]      diff,
  output logic              underflow
);
  logic [W:0] wide;
  assign wide      = {1'b0, minuend} - {1'b0, subtrahend};
  assign underflow = wide[W];
  assign diff      = (saturate && underflow) ? '0 : wide[W-1:0];
endmodule

// ===== core/packed_subtract_unit.sv
`timescale 1ns/10ps
// Functional notes
// - Major bits zero plus minor code select halving word subtract, truncating.
// - Minor code with top bit set selects the rounding halving form.
// - Two minor codes select wrapping and saturating halfword-pair subtract.
// - Halving word: sign-extend both to 33 bits, first minus second.
// - Truncating form writes intermediate bits 32..1.
// - Rounding form adds one, then writes bits 32..1.
// - Halving word never touches the control register.
// - No operand-dependent exceptions are raised.
// - Pair lanes zero-extended; second-field source minus first-field source.
// - Saturating pair lane underflow gives zero.
// - Pair underflow in either lane sets control bit 20.
// - Quad lanes: first source minus second, 9-bit unsigned.
// - Wrapping quad lane keeps difference modulo 256.
// - Saturating quad lane underflow gives zero.
// - Quad underflow in any lane sets control bit 20.
module packed_subtract_unit (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                clk_en,
  input  wire logic                issue,
  input  wire logic [31:0]         insn,
  input  wire logic [31:0]         first_src,
  input  wire logic [31:0]         second_src,
  input  wire logic                ctrl_load,
  input  wire logic [31:0]         ctrl_load_data,
  output logic [4:0]               first_sel,
  output logic [4:0]               second_sel,
  output psu_pkg::wb_t             wb,
  output logic                     illegal,
  output logic [31:0]              extension_control_register
);
  psu_pkg::sub_op_t op;
  logic [4:0]       dest_sel;
  logic [32:0]      interim;
  logic [32:0]      rounded;
  logic [31:0]      halving_res;
  logic [15:0]      pair_diff [2];
  logic [1:0]       pair_uf;
  logic [7:0]       quad_diff [4];
  logic [3:0]       quad_uf;
  logic             pair_sat;
  logic             quad_sat;
  logic             is_pair;
  logic             is_quad;
  logic [31:0]      result_nxt;
  logic             flag_set_nxt;
  logic             pair_uf_any;
  logic             quad_uf_any;

  sub_decoder u_dec (
    .insn       (insn),
    .op         (op),
    .first_sel  (first_sel),
    .second_sel (second_sel),
    .dest_sel   (dest_sel)
  );

  assign interim     = {first_src[31], first_src} - {second_src[31], second_src};
  assign rounded     = interim + 33'h0_0000_0001;
  assign halving_res = (op == psu_pkg::OP_HWS_RND) ? rounded[32:1]
                                                   : interim[32:1];

  assign pair_sat = (op == psu_pkg::OP_PAIR_SAT);
  assign quad_sat = (op == psu_pkg::OP_QUAD_SAT);
  assign is_pair  = (op == psu_pkg::OP_PAIR) || pair_sat;
  assign is_quad  = (op == psu_pkg::OP_QUAD) || quad_sat;

  // Pair lanes take first source from second; quad lanes do the reverse
  genvar g;
  for (g = 0; g < 2; g++) begin : g_pair
    lane_sub #(.W(16)) u_pair (
      .minuend    (second_src[16*g+15:16*g]),
      .subtrahend (first_src[16*g+15:16*g]),
      .saturate   (pair_sat),
      .diff       (pair_diff[g]),
      .underflow  (pair_uf[g])
    );
  end
  for (g = 0; g < 4; g++) begin : g_quad
    lane_sub #(.W(8)) u_quad (
      .minuend    (first_src[8*g+7:8*g]),
      .subtrahend (second_src[8*g+7:8*g]),
      .saturate   (quad_sat),
      .diff       (quad_diff[g]),
      .underflow  (quad_uf[g])
    );
  end

  assign pair_uf_any = |pair_uf;
  assign quad_uf_any = |quad_uf;

  always_comb begin
    result_nxt   = halving_res;
    flag_set_nxt = 1'b0;
    if (is_pair) begin
      result_nxt   = {pair_diff[1], pair_diff[0]};
      flag_set_nxt = pair_uf_any;
    end else if (is_quad) begin
      result_nxt   = {quad_diff[3], quad_diff[2], quad_diff[1], quad_diff[0]};
      flag_set_nxt = quad_uf_any;
    end
  end

  // Result register; no trap path exists regardless of data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wb      <= '{valid: 1'b0, dest: 5'h00, data: psu_pkg::RESULT_RESET};
      illegal <= 1'b0;
    end else if (clk_en) begin
      wb.valid <= issue && (op != psu_pkg::OP_NONE);
      wb.dest  <= dest_sel;
      wb.data  <= result_nxt;
      illegal  <= issue && (op == psu_pkg::OP_NONE);
    end
  end

  // Flag set wins over a same-cycle external load of that bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      extension_control_register <= psu_pkg::CTRL_RESET;
    end else if (clk_en) begin
      if (ctrl_load) begin
        extension_control_register <= ctrl_load_data;
      end
      if (issue && flag_set_nxt) begin
        extension_control_register[psu_pkg::OUFLAG_BIT] <= 1'b1;
      end
    end
  end

  // Own view of the word, so the decode checks do not lean on the decoder
  logic        major_hit;
  logic [10:0] minor_code;
  assign major_hit  = (insn[psu_pkg::MAJOR_MSB:psu_pkg::MAJOR_LSB] == psu_pkg::MAJOR_GROUP);
  assign minor_code = insn[psu_pkg::MINOR_MSB:0];

  // Decode and answer timing
  a_dec_word: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && major_hit && minor_code == psu_pkg::MINOR_HWS |=>
    wb.valid && !illegal)
    else $error("halving word not decoded");

  a_dec_round: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && major_hit && minor_code == psu_pkg::MINOR_HWS_RND |=>
    wb.valid && !illegal)
    else $error("rounding halve not decoded");

  a_dec_pair: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && major_hit && (minor_code == psu_pkg::MINOR_PAIR ||
    minor_code == psu_pkg::MINOR_PAIR_SAT) |=> wb.valid && !illegal)
    else $error("pair subtract not decoded");

  a_dec_quad: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && major_hit && (minor_code == psu_pkg::MINOR_QUAD ||
    minor_code == psu_pkg::MINOR_QUAD_SAT) |=> wb.valid && !illegal)
    else $error("quad subtract not decoded");

  a_dec_major: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && !major_hit |=>
    !wb.valid && illegal)
    else $error("foreign group accepted");

  a_dest_field: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue |=>
    wb.dest == $past(insn[psu_pkg::DEST_MSB:psu_pkg::DEST_LSB]))
    else $error("destination field wrong");

  a_result_pulse: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !issue |=>
    !wb.valid && !illegal)
    else $error("pulse without issue");

  a_illegal_op: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_NONE |=>
    illegal && !wb.valid)
    else $error("unknown word not refused");

  // Halving word
  a_word_trunc: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_HWS |=> wb.valid &&
    wb.data == $past(interim[32:1]))
    else $error("truncating halve wrong");

  a_word_round: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_HWS_RND |=>
    wb.data == $past(rounded[32:1]))
    else $error("rounding halve wrong");

  a_word_even: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_HWS_RND && !interim[0] |=>
    wb.data == $past(interim[32:1]))
    else $error("even interim rounded up");

  a_word_odd: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_HWS_RND && interim[0] |=>
    wb.data == $past(interim[32:1]) + 32'h0000_0001)
    else $error("odd interim not rounded up");

  a_word_equal: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && (op == psu_pkg::OP_HWS || op == psu_pkg::OP_HWS_RND) &&
    first_src == second_src |=> wb.data == 32'h0000_0000)
    else $error("equal operands not zero");

  a_word_noflag: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && !ctrl_load && (op == psu_pkg::OP_HWS || op == psu_pkg::OP_HWS_RND)
    |=> $stable(extension_control_register))
    else $error("halve changed control");

  // Halfword pair
  a_pair_wrap_lo: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_PAIR |=>
    wb.data[15:0] == $past(second_src[15:0] - first_src[15:0]))
    else $error("pair low lane wrong");

  a_pair_wrap_hi: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_PAIR |=>
    wb.data[31:16] == $past(second_src[31:16] - first_src[31:16]))
    else $error("pair high lane wrong");

  a_pair_sat: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && pair_sat && second_src[15:0] < first_src[15:0] |=>
    wb.data[15:0] == 16'h0000)
    else $error("pair lane not clamped");

  a_pair_sat_hi: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && pair_sat && second_src[31:16] < first_src[31:16] |=>
    wb.data[31:16] == 16'h0000)
    else $error("pair high lane not clamped");

  a_pair_keep: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && pair_sat && second_src[15:0] >= first_src[15:0] |=>
    wb.data[15:0] == $past(second_src[15:0] - first_src[15:0]))
    else $error("pair lane clamped needlessly");

  a_pair_flag: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && is_pair && second_src[31:16] < first_src[31:16] |=>
    extension_control_register[psu_pkg::OUFLAG_BIT])
    else $error("pair flag missing");

  a_pair_flag_lo: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && is_pair && second_src[15:0] < first_src[15:0] |=>
    extension_control_register[psu_pkg::OUFLAG_BIT])
    else $error("pair low flag missing");

  // Quad byte
  a_quad_wrap: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_QUAD |=>
    wb.data[7:0] == $past(first_src[7:0] - second_src[7:0]))
    else $error("quad wrap wrong");

  a_quad_wrap_hi: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && op == psu_pkg::OP_QUAD |=>
    wb.data[31:24] == $past(first_src[31:24] - second_src[31:24]))
    else $error("quad top lane wrong");

  a_quad_sat: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && quad_sat && first_src[31:24] < second_src[31:24] |=>
    wb.data[31:24] == 8'h00)
    else $error("quad lane not clamped");

  a_quad_sat_lo: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && quad_sat && first_src[7:0] < second_src[7:0] |=>
    wb.data[7:0] == 8'h00)
    else $error("quad low lane not clamped");

  a_quad_sat_keep: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && quad_sat && first_src[23:16] >= second_src[23:16] |=>
    wb.data[23:16] == $past(first_src[23:16] - second_src[23:16]))
    else $error("quad lane clamped needlessly");

  a_quad_flag: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && is_quad && first_src[15:8] < second_src[15:8] |=>
    extension_control_register[psu_pkg::OUFLAG_BIT])
    else $error("quad flag missing");

  a_quad_flag_top: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && issue && is_quad && first_src[31:24] < second_src[31:24] |=>
    extension_control_register[psu_pkg::OUFLAG_BIT])
    else $error("quad top flag missing");

  // Control register
  a_other_bits: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_load |=> extension_control_register[19:0] ==
    $past(extension_control_register[19:0]))
    else $error("other control bits moved");

  a_upper_bits: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_load |=> extension_control_register[31:21] ==
    $past(extension_control_register[31:21]))
    else $error("upper control bits moved");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_load && extension_control_register[psu_pkg::OUFLAG_BIT] |=>
    extension_control_register[psu_pkg::OUFLAG_BIT])
    else $error("overflow flag cleared");

  a_flag_only_op: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && !ctrl_load && !extension_control_register[psu_pkg::OUFLAG_BIT] &&
    !(issue && (is_pair || is_quad)) |=> !extension_control_register[psu_pkg::OUFLAG_BIT])
    else $error("overflow flag set unprompted");

  a_ctrl_load: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && ctrl_load && !(issue && flag_set_nxt) |=>
    extension_control_register == $past(ctrl_load_data))
    else $error("control load lost");

  a_set_over_load: assert property (@(posedge core_clk) disable iff (rst)
    clk_en && ctrl_load && issue && flag_set_nxt |=>
    extension_control_register[psu_pkg::OUFLAG_BIT])
    else $error("load beat the flag set");

  a_freeze_state: assert property (@(posedge core_clk) disable iff (rst)
    !clk_en |=> $stable(wb) && $stable(illegal) &&
    $stable(extension_control_register))
    else $error("state moved while frozen");
endmodule

// ===== tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic         core_clk, rst, clk_en, issue, ctrl_load, illegal;
  logic [31:0]  insn, first_src, second_src, ctrl_load_data, ctrl, ctrl_exp;
  logic [4:0]   first_sel, second_sel;
  psu_pkg::wb_t wb;
  int           err_count, tests_run;

  packed_subtract_unit i_packed_subtract_unit (.core_clk(core_clk), .rst(rst),
    .clk_en(clk_en), .issue(issue), .insn(insn), .first_src(first_src),
    .second_src(second_src), .ctrl_load(ctrl_load), .ctrl_load_data(ctrl_load_data),
    .first_sel(first_sel), .second_sel(second_sel), .wb(wb), .illegal(illegal),
    .extension_control_register(ctrl));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // Family from minor bits 9..0, bit 10 picks rounding or clamping
  function automatic logic [31:0] ref_res(input logic [10:0] m, input logic [31:0] a,
                                          input logic [31:0] b, output logic uf);
    logic [32:0] w;
    logic [16:0] h;
    logic [8:0]  q;
    logic [31:0] r;
    uf = 1'b0;
    w = {a[31], a} - {b[31], b} + {32'h0, m[10]};
    r = w[32:1];
    for (int i = 0; i < 2 && m[9:0] == psu_pkg::MINOR_PAIR[9:0]; i++) begin
      h = {1'b0, b[16*i+:16]} - {1'b0, a[16*i+:16]};
      uf |= h[16];
      r[16*i+:16] = (m[10] && h[16]) ? 16'h0000 : h[15:0];
    end
    for (int i = 0; i < 4 && m[9:0] == psu_pkg::MINOR_QUAD[9:0]; i++) begin
      q = {1'b0, a[8*i+:8]} - {1'b0, b[8*i+:8]};
      uf |= q[8];
      r[8*i+:8] = (m[10] && q[8]) ? 8'h00 : q[7:0];
    end
    return r;
  endfunction

  task automatic send(input logic [31:0] w, input logic [31:0] a, input logic [31:0] b,
                      input logic en);
    @(posedge core_clk);
    insn <= w;
    first_src <= a;
    second_src <= b;
    issue <= 1'b1;
    clk_en <= en;
    @(posedge core_clk);
    issue <= 1'b0;
    clk_en <= 1'b1;
    #1;
  endtask

  task automatic load_ctrl(input logic [31:0] v);
    @(posedge core_clk);
    ctrl_load <= 1'b1;
    ctrl_load_data <= v;
    @(posedge core_clk);
    ctrl_load <= 1'b0;
    ctrl_exp = v;
  endtask

  task automatic do_op(input logic [10:0] m, input logic [31:0] a, input logic [31:0] b);
    logic        uf;
    logic [31:0] e;
    e = ref_res(m, a, b, uf);
    send({psu_pkg::MAJOR_GROUP, 5'h03, 5'h04, 5'h09, m}, a, b, 1'b1);
    ctrl_exp = ctrl_exp | ({31'h0, uf} << psu_pkg::OUFLAG_BIT);
    chk({31'h0, wb.valid}, 32'h1);
    chk({27'h0, wb.dest}, 32'h9);
    chk({22'h0, first_sel, second_sel}, {22'h0, 5'h04, 5'h03});
    chk(wb.data, e);
    chk(ctrl, ctrl_exp);
    chk({31'h0, illegal}, 32'h0);
  endtask

  task automatic t_reset;
    chk(wb.data, 32'h0); chk({31'h0, wb.valid}, 32'h0); chk(ctrl, 32'h0);
  endtask

  task automatic t_halving;
    logic [31:0] ta[4] = '{32'h8000_0000, 32'h7FFF_FFFF, 32'h0000_0005, 32'hFFFF_FFFE};
    load_ctrl(32'hFFEF_FFFF);
    do_op(psu_pkg::MINOR_HWS_RND, 32'h1234_5678, 32'h1234_5678);
    for (int i = 0; i < 4; i++) begin
      do_op(psu_pkg::MINOR_HWS, ta[i], ta[3-i]);
      do_op(psu_pkg::MINOR_HWS_RND, ta[i], ta[3-i]);
    end
  endtask

  task automatic t_lanes;
    logic [10:0] ms[4] = '{psu_pkg::MINOR_PAIR, psu_pkg::MINOR_PAIR_SAT,
                           psu_pkg::MINOR_QUAD, psu_pkg::MINOR_QUAD_SAT};
    for (int i = 0; i < 4; i++) begin
      load_ctrl(32'h0);
      do_op(ms[i], 32'h10FF_0080, 32'h2001_0180);
      load_ctrl(32'h0);
      do_op(ms[i], 32'h2001_0180, 32'h10FF_0080);
    end
  endtask

  task automatic t_sticky;
    load_ctrl(32'h5A0F_00F3);
    do_op(psu_pkg::MINOR_QUAD_SAT, 32'h0001_0000, 32'h0100_0001);
    do_op(psu_pkg::MINOR_QUAD, 32'hFF80_7F01, 32'h0180_7E00);
    do_op(psu_pkg::MINOR_HWS, 32'h0000_0003, 32'h0000_0007);
  endtask

  task automatic t_refuse;
    load_ctrl(32'h0);
    send({6'h01, 15'h0, psu_pkg::MINOR_HWS}, 32'h1, 32'h2, 1'b1);
    chk({30'h0, wb.valid, illegal}, 32'h1);
    send({psu_pkg::MAJOR_GROUP, 15'h0, 11'h000}, 32'h1, 32'h2, 1'b1);
    chk({30'h0, wb.valid, illegal}, 32'h1);
    send({psu_pkg::MAJOR_GROUP, 15'h0, psu_pkg::MINOR_QUAD}, 32'h0, 32'hFF, 1'b0);
    chk({30'h0, wb.valid, illegal}, 32'h0);
    chk(ctrl, 32'h0);
  endtask

  // Load and underflow in one cycle: the flag set must survive the load
  task automatic t_collide;
    @(posedge core_clk);
    ctrl_load <= 1'b1;
    ctrl_load_data <= 32'h0000_0001;
    insn <= {psu_pkg::MAJOR_GROUP, 10'h000, 5'h09, psu_pkg::MINOR_QUAD};
    first_src <= 32'h0000_0000;
    second_src <= 32'h0000_0001;
    issue <= 1'b1;
    @(posedge core_clk);
    ctrl_load <= 1'b0;
    issue <= 1'b0;
    #1;
    chk({31'h0, wb.valid}, 32'h1);
    chk(ctrl, 32'h0010_0001);
  endtask

  task automatic summarize;
    $display("mismatches=%0d comparisons=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #300000;
    err_count++;
    summarize();
  end

  initial begin
    rst = 1'b1; clk_en = 1'b1; issue = 1'b0; ctrl_load = 1'b0;
    insn = 32'h0; first_src = 32'h0; second_src = 32'h0; ctrl_load_data = 32'h0;
    ctrl_exp = 32'h0; err_count = 0; tests_run = 0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_halving();
    t_lanes();
    t_sticky();
    t_refuse();
    t_collide();
    summarize();
  end
endmodule
